// [core/ccdrs_pkg.sv]
// Package for the CCD readout sequencer: constants, timing and carriers
package ccdrs_pkg;

  // ==========================================================
  // Clock and pixel timing
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned IL_PIX_MHZ = 16;
  localparam int unsigned FF_PIX_MHZ = 2;
  // Cycles per pixel, rounded down so the pixel rate is never below nominal
  localparam int unsigned IL_PIX_CYC = CLK_MHZ / IL_PIX_MHZ;
  localparam int unsigned FF_PIX_CYC = CLK_MHZ / FF_PIX_MHZ;
  // Dual-port digitizes two pixels per pixel period
  localparam int unsigned DUAL_PIX_PER_STEP = 2;

  // ==========================================================
  // Geometry widths and reset values
  localparam int unsigned DIM_W = 12;
  localparam int unsigned TIME_W = 32;
  localparam int unsigned PIX_W = 16;
  localparam logic [DIM_W-1:0] FULL_COLS = 12'h400;
  localparam logic [DIM_W-1:0] FULL_ROWS_IL = 12'h400;
  localparam logic [DIM_W-1:0] FULL_ROWS_FF = 12'h100;
  localparam logic [TIME_W-1:0] LINE_XFER_CYC_RST = 32'h0000_0010;
  localparam logic [TIME_W-1:0] STORE_XFER_CYC_RST = 32'h0000_0008;
  localparam logic [TIME_W-1:0] DECAY_CYC_RST = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef enum logic
  {
    CCDRS_INTERLINE,
    CCDRS_FULLFRAME
  } ccdrs_sensor_e;

  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_STORE,
    ST_LINE,
    ST_PIXEL,
    ST_DECAY
  } ccdrs_state_e;

  typedef struct packed
  {
    logic [DIM_W-1:0] col_start;
    logic [DIM_W-1:0] col_count;
    logic [DIM_W-1:0] row_start;
    logic [DIM_W-1:0] row_count;
    logic full_image;
    logic multi_roi;
  } ccdrs_roi_s;

  typedef struct packed
  {
    logic valid;
    logic port_b;
    logic keep;
    logic [DIM_W-1:0] col;
    logic [DIM_W-1:0] row;
  } ccdrs_pix_s;

endpackage : ccdrs_pkg

// [core/ccdrs_port_sel.sv]
// Readout port selection from ROI geometry
`timescale 1ns/1ps
module ccdrs_port_sel
  import ccdrs_pkg::*;
(
  // Sensor and geometry
  input wire ccdrs_pkg::ccdrs_sensor_e sensor,
  input wire ccdrs_pkg::ccdrs_roi_s roi,
  // Decision
  output logic dual_port,
  output logic roi_reject
);
  logic [DIM_W:0] right_gap;
  logic centred;

  always_comb
  begin
    right_gap = {1'b0, FULL_COLS} - {1'b0, roi.col_start} - {1'b0, roi.col_count};
    centred = (right_gap == {1'b0, roi.col_start});
    // Full-frame part has one port only; fixed port, never selectable
    if (sensor == CCDRS_FULLFRAME)
    begin
      dual_port = 1'b0;
    end
    else
    begin
      dual_port = roi.full_image | centred;
    end
    // Several regions only in single-port readout
    roi_reject = dual_port & roi.multi_roi & ~roi.full_image;
  end
endmodule : ccdrs_port_sel

// [core/ccdrs_rd_time.sv]
// Readout time estimate and overlap decision
`timescale 1ns/1ps
module ccdrs_rd_time
  import ccdrs_pkg::*;
(
  // Geometry in effect
  input wire logic [ccdrs_pkg::DIM_W-1:0] cols,
  input wire logic [ccdrs_pkg::DIM_W-1:0] rows,
  input wire logic [ccdrs_pkg::TIME_W-1:0] pix_cyc,
  input wire logic [ccdrs_pkg::TIME_W-1:0] line_cyc,
  input wire logic [ccdrs_pkg::TIME_W-1:0] exp_cyc,
  // Result
  output logic [ccdrs_pkg::TIME_W-1:0] rd_cyc,
  output logic non_overlap
);
  logic [2*TIME_W-1:0] full;

  always_comb
  begin
    // rows*cols*(shift+digitize) + rows*line transfer
    full = ({{(2*TIME_W-DIM_W){1'b0}}, rows} * {{(2*TIME_W-DIM_W){1'b0}}, cols}
      * {{TIME_W{1'b0}}, pix_cyc}) + ({{(2*TIME_W-DIM_W){1'b0}}, rows}
      * {{TIME_W{1'b0}}, line_cyc});
    rd_cyc = (|full[2*TIME_W-1:TIME_W]) ? {TIME_W{1'b1}} : full[TIME_W-1:0];
    non_overlap = (exp_cyc < rd_cyc);
  end
endmodule : ccdrs_rd_time

// [core/ccdrs_top.sv]
// CCD readout sequencer: exposure gating, row/pixel stepping and digitize strobes
`timescale 1ns/1ps
module ccdrs_top
  import ccdrs_pkg::*;
#(
  parameter int unsigned DIMW = DIM_W
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Acquisition control
  input wire ccdrs_pkg::ccdrs_sensor_e sensor,
  input wire ccdrs_pkg::ccdrs_roi_s roi,
  input wire logic [ccdrs_pkg::TIME_W-1:0] exp_cyc,
  input wire logic [ccdrs_pkg::TIME_W-1:0] line_cyc,
  input wire logic [ccdrs_pkg::TIME_W-1:0] store_cyc,
  input wire logic [ccdrs_pkg::TIME_W-1:0] decay_cyc,
  input wire logic start,
  input wire logic stop,
  // Sensor pins
  output logic gate_on,
  output logic store_xfer,
  output logic row_shift,
  output logic pix_shift,
  output logic digitize,
  output ccdrs_pkg::ccdrs_pix_s pix,
  // Status
  output logic busy,
  output logic dual_port,
  output logic non_overlap,
  output logic roi_reject,
  output logic roi_bad_width,
  output logic [ccdrs_pkg::TIME_W-1:0] rd_cyc,
  output logic frame_done
);
  import ccdrs_pkg::*;

  // ==========================================================
  // State
  typedef struct packed
  {
    ccdrs_state_e st;
    logic running;
    logic exposing;
    logic exp_pending;
    logic no_ovl;
    logic dual;
    logic [TIME_W-1:0] exp_cnt;
    logic [TIME_W-1:0] cnt;
    logic [DIM_W-1:0] row;
    logic [DIM_W-1:0] col;
    logic store_p;
    logic row_p;
    logic pix_p;
    logic dig_p;
    ccdrs_pix_s pix;
    logic done_p;
    logic [TIME_W-1:0] rd;
  } ccdrs_reg_s;

  ccdrs_reg_s r_q;
  ccdrs_reg_s r_d;

  logic dual_w;
  logic reject_w;
  logic no_ovl_w;
  logic [TIME_W-1:0] rd_w;
  logic [DIM_W-1:0] rows_all;
  logic [TIME_W-1:0] pix_cyc;
  logic [DIM_W-1:0] col_step;
  logic in_roi;
  logic row_last;
  logic col_last;
  logic bad_w;

  // ==========================================================
  // Helpers
  function automatic logic [TIME_W-1:0] dec_cnt(input logic [TIME_W-1:0] v);
    dec_cnt = (v == '0) ? '0 : v - 1'b1;
  endfunction : dec_cnt

  // Phase counters load their full length and end on the cycle they read one
  function automatic logic cnt_end(input logic [TIME_W-1:0] v);
    cnt_end = (v <= TIME_W'(1));
  endfunction : cnt_end

  function automatic logic is_full_frame(input ccdrs_sensor_e s);
    is_full_frame = (s == CCDRS_FULLFRAME);
  endfunction : is_full_frame

  // Record handed out with every digitize strobe
  function automatic ccdrs_pix_s pix_rec(input logic keep, input logic port_b,
    input logic [DIM_W-1:0] col, input logic [DIM_W-1:0] row);
    pix_rec.valid = 1'b1;
    pix_rec.keep = keep;
    pix_rec.port_b = port_b;
    pix_rec.col = col;
    pix_rec.row = row;
  endfunction : pix_rec

  function automatic logic inside_span(input logic [DIM_W-1:0] p,
    input logic [DIM_W-1:0] s, input logic [DIM_W-1:0] n);
    inside_span = (p >= s) && ({1'b0, p} < ({1'b0, s} + {1'b0, n}));
  endfunction : inside_span

  // ==========================================================
  // Port choice and readout estimate
  ccdrs_port_sel u_port_sel
  (
    .sensor(sensor),
    .roi(roi),
    .dual_port(dual_w),
    .roi_reject(reject_w)
  );

  // Whole array is clocked out, so timing uses full geometry; ROI gives no saving here
  ccdrs_rd_time u_rd_time
  (
    .cols(FULL_COLS),
    .rows(rows_all),
    .pix_cyc(pix_cyc),
    .line_cyc(line_cyc),
    .exp_cyc(exp_cyc),
    .rd_cyc(rd_w),
    .non_overlap(no_ovl_w)
  );

  // ==========================================================
  // Geometry decode
  always_comb
  begin
    rows_all = is_full_frame(sensor) ? FULL_ROWS_FF : FULL_ROWS_IL;
    // Whole clocks per pixel, rounded down, keep the pixel rate at or above nominal
    pix_cyc = is_full_frame(sensor) ? TIME_W'(FF_PIX_CYC) : TIME_W'(IL_PIX_CYC);
    col_step = r_q.dual ? DIM_W'(DUAL_PIX_PER_STEP) : DIM_W'(1);
    // Width check is reported only; the other party must supply valid geometry
    bad_w = (roi.col_count[1:0] != 2'b00) & ~roi.full_image;
    in_roi = roi.full_image | (inside_span(r_q.col, roi.col_start, roi.col_count)
      & inside_span(r_q.row, roi.row_start, roi.row_count));
    row_last = ({1'b0, r_q.row} + 1'b1) >= {1'b0, rows_all};
    // Dual-port halves the column walk: both ends drain toward the centre
    col_last = r_q.dual ? (({1'b0, r_q.col} + (DIM_W+1)'(DUAL_PIX_PER_STEP))
      >= {1'b0, FULL_COLS}) : (({1'b0, r_q.col} + 1'b1) >= {1'b0, FULL_COLS});
  end

  // ==========================================================
  // Sequencer
  always_comb
  begin
    r_d = r_q;
    r_d.store_p = 1'b0;
    r_d.row_p = 1'b0;
    r_d.pix_p = 1'b0;
    r_d.dig_p = 1'b0;
    r_d.pix.valid = 1'b0;
    r_d.done_p = 1'b0;
    // Estimate is registered so the status word never shows a settling product
    r_d.rd = rd_w;
    if (start)
    begin
      r_d.running = 1'b1;
    end
    if (stop)
    begin
      r_d.running = 1'b0;
    end
    // Exposure timer runs independently of readout when overlapped
    if (r_q.exposing)
    begin
      r_d.exp_cnt = dec_cnt(r_q.exp_cnt);
      if (cnt_end(r_q.exp_cnt))
      begin
        r_d.exposing = 1'b0;
        r_d.exp_pending = 1'b1;
      end
    end
    case (r_q.st)
      ST_IDLE:
      begin
        // A rejected region parks the finished exposure until the geometry is legal
        if (r_q.exp_pending & ~reject_w)
        begin
          r_d.exp_pending = 1'b0;
          // Mode and overlap are frozen per frame; roi and sensor stay live for keep, row count and pixel timing
          r_d.dual = dual_w;
          r_d.no_ovl = no_ovl_w;
          r_d.row = '0;
          r_d.col = '0;
          if (sensor == CCDRS_INTERLINE)
          begin
            r_d.st = ST_STORE;
            r_d.store_p = 1'b1;
            r_d.cnt = store_cyc;
          end
          else
          begin
            r_d.st = ST_LINE;
            r_d.row_p = 1'b1;
            r_d.cnt = line_cyc;
          end
          // Overlapped: next exposure begins with this readout
          if (~no_ovl_w & r_q.running)
          begin
            r_d.exposing = 1'b1;
            r_d.exp_cnt = exp_cyc;
          end
        end
        else if (r_q.running & ~r_q.exposing & ~r_q.exp_pending)
        begin
          // Array empty: expose at once, no clearing pass
          r_d.exposing = 1'b1;
          r_d.exp_cnt = exp_cyc;
        end
      end
      ST_STORE:
      begin
        // No row may move until the storage transfer has settled
        r_d.cnt = dec_cnt(r_q.cnt);
        if (cnt_end(r_q.cnt))
        begin
          r_d.st = ST_LINE;
          r_d.row_p = 1'b1;
          r_d.cnt = line_cyc;
        end
      end
      ST_LINE:
      begin
        // Each row pays the line transfer before its first pixel
        r_d.cnt = dec_cnt(r_q.cnt);
        if (cnt_end(r_q.cnt))
        begin
          r_d.st = ST_PIXEL;
          r_d.col = '0;
          r_d.cnt = pix_cyc;
        end
      end
      ST_PIXEL:
      begin
        r_d.cnt = dec_cnt(r_q.cnt);
        if (cnt_end(r_q.cnt))
        begin
          // Shift into node and digitize together; out-of-ROI data discarded
          r_d.pix_p = 1'b1;
          r_d.dig_p = 1'b1;
          // Dual walk names one column per step; its mirror on the far port is implied
          r_d.pix = pix_rec(in_roi, r_q.dual, r_q.col, r_q.row);
          r_d.cnt = pix_cyc;
          r_d.col = r_q.col + col_step;
          if (col_last)
          begin
            // Last pixel of the row is digitized in the same cycle the next row moves
            r_d.col = '0;
            if (row_last)
            begin
              r_d.st = is_full_frame(sensor) ? ST_DECAY : ST_IDLE;
              r_d.cnt = decay_cyc;
              r_d.done_p = 1'b1;
            end
            else
            begin
              r_d.row = r_q.row + 1'b1;
              r_d.st = ST_LINE;
              r_d.row_p = 1'b1;
              r_d.cnt = line_cyc;
            end
          end
        end
      end
      ST_DECAY:
      begin
        // Phosphor decay is added to the frame period
        r_d.cnt = dec_cnt(r_q.cnt);
        if (cnt_end(r_q.cnt))
        begin
          r_d.st = ST_IDLE;
        end
      end
      default:
      begin
        r_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      r_q <= '0;
      r_q.st <= ST_IDLE;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Outputs
  always_comb
  begin
    // Overlap leaves the gate open while rows drain, which is what buys frame rate
    // Gate stays off whenever a non-overlapped readout is in progress
    gate_on = r_q.exposing & ~((r_q.st != ST_IDLE) & r_q.no_ovl);
    store_xfer = r_q.store_p;
    row_shift = r_q.row_p;
    pix_shift = r_q.pix_p;
    digitize = r_q.dig_p;
    pix = r_q.pix;
    busy = (r_q.st != ST_IDLE);
    dual_port = r_q.dual;
    non_overlap = r_q.no_ovl;
    roi_reject = reject_w;
    roi_bad_width = bad_w;
    rd_cyc = r_q.rd;
    frame_done = r_q.done_p;
  end
endmodule : ccdrs_top

// [verif/ccdrs_sensor_model.sv]
// Behavioural sensor array watching the sequencer drive
`timescale 1ns/1ps
module ccdrs_sensor_model
  import ccdrs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Sequencer drive
  input wire logic gate_on,
  input wire logic digitize,
  // Sticky: light reached the array while a pixel was read
  output logic lit_q
);
  always_ff @(posedge mclk)
  begin
    if (srst)
      lit_q <= 1'b0;
    else
      lit_q <= lit_q | (gate_on & digitize);
  end
endmodule : ccdrs_sensor_model

// [verif/ccdrs_sva.sv]
// Port checker for the readout sequencer
`timescale 1ns/1ps
module ccdrs_sva
  import ccdrs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Observed
  input wire ccdrs_pkg::ccdrs_sensor_e sensor,
  input wire logic gate_on,
  input wire logic store_xfer,
  input wire logic row_shift,
  input wire logic pix_shift,
  input wire logic digitize,
  input wire ccdrs_pkg::ccdrs_pix_s pix,
  input wire logic busy,
  input wire logic dual_port,
  input wire logic non_overlap,
  input wire logic roi_reject,
  input wire logic frame_done
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);
  // ==========
  // Row counters; first row shift of a frame is skipped as no row came before
  logic [10:0] cnt_q;
  logic [5:0] gap_q;
  logic row_q;
  always_ff @(posedge mclk)
  begin
    cnt_q <= (srst || row_shift) ? 11'h0 : cnt_q + 11'(digitize);
    gap_q <= (srst || digitize) ? 6'h0 : gap_q + 6'(gap_q != 6'h3f);
    row_q <= (srst || !busy || store_xfer) ? 1'b0 : row_q | row_shift;
  end
  sequence s_last_pix;
    digitize && pix.valid;
  endsequence
  // ==========
  // Properties
  AST_STORE_IL: assert property (store_xfer |-> sensor == CCDRS_INTERLINE)
    else $error("store transfer on full-frame sensor");
  AST_GATE_OFF: assert property (busy && non_overlap |-> !gate_on)
    else $error("gate on in non-overlapped readout");
  AST_PIX_PAIR: assert property (digitize |-> pix_shift && pix.valid)
    else $error("digitize without shift");
  AST_PIX_RATE: assert property (
    digitize && row_q && cnt_q != 11'h0
    |-> gap_q == (sensor == CCDRS_FULLFRAME ? 6'd61 : 6'd6))
    else $error("pixel spacing wrong");
  AST_ROW_FULL: assert property (
    row_shift && row_q |-> cnt_q + 11'(digitize) == (dual_port ? 11'd512 : 11'd1024))
    else $error("row shifted before row done");
  AST_ONE_PORT: assert property (busy && sensor == CCDRS_FULLFRAME |-> !dual_port)
    else $error("dual port on full-frame");
  AST_PORT_FLAG: assert property (digitize |-> pix.port_b == dual_port)
    else $error("port flag wrong");
  AST_REJECT: assert property (roi_reject && !busy |=> !busy)
    else $error("readout began on rejected region");
  AST_DONE: assert property (frame_done |-> s_last_pix ##1 !frame_done)
    else $error("frame done misplaced");
endmodule : ccdrs_sva

bind ccdrs_top ccdrs_sva u_sva (.mclk(mclk), .srst(srst), .sensor(sensor),
  .gate_on(gate_on), .store_xfer(store_xfer), .row_shift(row_shift),
  .pix_shift(pix_shift), .digitize(digitize), .pix(pix), .busy(busy),
  .dual_port(dual_port), .non_overlap(non_overlap), .roi_reject(roi_reject),
  .frame_done(frame_done));

// [verif/tb_ccdrs_top.sv]
// Testbench for the CCD readout sequencer
`timescale 1ns/1ps
module tb_ccdrs_top;
  import ccdrs_pkg::*;
  typedef struct packed
  {
    ccdrs_sensor_e sens;
    ccdrs_roi_s roi;
    logic dual;
    logic rej;
    logic bad;
  } ccdrs_case_s;
  localparam logic [31:0] EXP = 32'h14;
  localparam logic [31:0] STORE = 32'h8;
  // Sensor, region, then dual, reject, bad width; widths are multiples of 4 except case 4 (12'hfa, bad width)
  localparam ccdrs_case_s CASES [6] = '{
    '{CCDRS_INTERLINE, '{12'h0, 12'h400, 12'h0, 12'h400, 1'b1, 1'b0}, 1'b1, 1'b0, 1'b0},
    '{CCDRS_INTERLINE, '{12'h180, 12'h100, 12'h0, 12'h10, 1'b0, 1'b0}, 1'b1, 1'b0, 1'b0},
    '{CCDRS_INTERLINE, '{12'h0, 12'h100, 12'h0, 12'h10, 1'b0, 1'b0}, 1'b0, 1'b0, 1'b0},
    '{CCDRS_INTERLINE, '{12'h180, 12'h100, 12'h0, 12'h10, 1'b0, 1'b1}, 1'b1, 1'b1, 1'b0},
    '{CCDRS_INTERLINE, '{12'h4, 12'hfa, 12'h0, 12'h10, 1'b0, 1'b0}, 1'b0, 1'b0, 1'b1},
    '{CCDRS_FULLFRAME, '{12'h0, 12'h400, 12'h0, 12'h100, 1'b1, 1'b0}, 1'b0, 1'b0, 1'b0}};
  logic mclk, srst, start, gate_on, store_xfer, row_shift, digitize, busy, lit;
  logic dual_port, non_overlap, roi_reject, roi_bad_width;
  logic pix_shift, frame_done;
  logic [31:0] rd_cyc;
  ccdrs_sensor_e sensor;
  ccdrs_roi_s roi;
  ccdrs_pix_s pix;
  int n_errors = 0;
  int check_count = 0;
  ccdrs_top dut (.mclk(mclk), .srst(srst), .sensor(sensor), .roi(roi), .exp_cyc(EXP),
    .line_cyc(32'h10), .store_cyc(STORE), .decay_cyc(32'h4), .start(start), .stop(1'b0),
    .gate_on(gate_on), .store_xfer(store_xfer), .row_shift(row_shift), .pix_shift(pix_shift),
    .digitize(digitize), .pix(pix), .busy(busy), .dual_port(dual_port),
    .non_overlap(non_overlap), .roi_reject(roi_reject), .roi_bad_width(roi_bad_width),
    .rd_cyc(rd_cyc), .frame_done(frame_done));
  ccdrs_sensor_model u_ccd (.mclk(mclk), .srst(srst), .gate_on(gate_on),
    .digitize(digitize), .lit_q(lit));
  // ==========
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic tick(inout int n);
    @(negedge mclk);
    n++;
  endtask : tick
  // Each case except the rejected one ends mid-frame, so the next reset also aborts a readout
  task automatic run_case(input int i);
    ccdrs_case_s c;
    int n;
    int k;
    logic [11:0] col;
    c = CASES[i];
    n = 0;
    k = 0;
    col = '0;
    srst = 1'b1;
    sensor = c.sens;
    roi = c.roi;
    tick(n);
    srst = 1'b0;
    tick(n);
    chk(busy | gate_on | digitize, 0);
    chk(roi_reject, c.rej);
    chk(roi_bad_width, c.bad);
    start = 1'b1;
    tick(n);
    start = 1'b0;
    if (c.rej)
    begin
      repeat (60) tick(n);
      chk(busy, 0);
      return;
    end
    n = 0;
    while (!gate_on && n < 40)
      tick(n);
    n = 0;
    while (gate_on && n < 99)
      tick(n);
    chk(n, EXP);
    while (!store_xfer && !row_shift && n < 200)
      tick(n);
    chk(store_xfer, c.sens == CCDRS_INTERLINE);
    n = 0;
    while (!row_shift && n < 99)
      tick(n);
    if (c.sens == CCDRS_INTERLINE)
      chk(n >= STORE && n <= STORE + 1, 1);
    chk(dual_port, c.dual);
    chk(non_overlap, 1);
    // Full array: rows * (cols * pixel cycles + 16 line cycles)
    chk(rd_cyc, c.sens == CCDRS_FULLFRAME ? 32'h00f8_1000 : 32'h0070_4000);
    tick(n);
    // The last pixel of a row is digitized in the cycle the next row moves
    while (n < 9999 && !(c.sens == CCDRS_FULLFRAME && k == 4))
    begin
      if (digitize)
      begin
        chk(pix_shift, 1);
        chk(frame_done, 0);
        if (k > 0)
          chk(n, c.sens == CCDRS_FULLFRAME ? FF_PIX_CYC : IL_PIX_CYC);
        if (k > 0)
          chk(pix.col - col, c.dual ? 2 : 1);
        chk(pix.port_b, c.dual);
        chk(pix.keep, c.roi.full_image || (pix.col >= c.roi.col_start
          && pix.col < c.roi.col_start + c.roi.col_count));
        col = pix.col;
        k++;
        n = 0;
      end
      if (row_shift)
        break;
      tick(n);
    end
    if (c.sens == CCDRS_INTERLINE)
    begin
      chk(k, c.dual ? 512 : 1024);
      tick(n);
      n = 0;
      while (!digitize && n < 200)
        tick(n);
      chk(pix.row, 1);
      chk(pix.col, 0);
    end
    chk(lit, 0);
    $display("test %0d done", i);
  endtask : run_case
  // ==========
  // Clock, sequence and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    srst = 1'b1;
    start = 1'b0;
    sensor = CCDRS_INTERLINE;
    roi = '0;
    repeat (3) @(negedge mclk);
    for (int i = 0; i < 6; i++)
      run_case(i);
    srst = 1'b1;
    @(negedge mclk);
    chk(busy | digitize | pix.valid, 0);
    $display("test reset done");
    complete_run;
  end
  initial
  begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    complete_run;
  end
endmodule : tb_ccdrs_top
